// ---- inc/acr_pkg.sv ----
// constants and field layout of the analog comparator register bank
package acr_pkg;
  // instance count and bus width
  localparam int ACR_NCMP = 3;
  localparam int ACR_DW   = 32;
  localparam int ACR_AW   = 16;

  // register byte offsets
  localparam logic [15:0] ACR_OFS_CTL1     = 16'hA000;
  localparam logic [15:0] ACR_OFS_CTL2     = 16'hA010;
  localparam logic [15:0] ACR_OFS_CTL3     = 16'hA020;
  localparam logic [15:0] ACR_OFS_STAT     = 16'hA060;
  localparam logic [15:0] ACR_OFS_IRQ_STAT = 16'hA080;
  localparam logic [15:0] ACR_OFS_IRQ_CLR  = 16'hA084;
  localparam logic [15:0] ACR_OFS_IRQ_EN   = 16'hA088;

  // alias selection, taken from address bits 3:2
  localparam int          ACR_ALIAS_LSB = 2;
  localparam logic [1:0]  ACR_ALIAS_RW  = 2'h0;
  localparam logic [1:0]  ACR_ALIAS_CLR = 2'h1;
  localparam logic [1:0]  ACR_ALIAS_SET = 2'h2;
  localparam logic [1:0]  ACR_ALIAS_INV = 2'h3;

  // control register field positions
  localparam int ACR_CTL_ON      = 15;
  localparam int ACR_CTL_OE      = 14;
  localparam int ACR_CTL_INV     = 13;
  localparam int ACR_CTL_RES     = 8;
  localparam int ACR_CTL_EDGE_LO = 6;
  localparam int ACR_CTL_POS     = 4;
  localparam int ACR_CTL_NEG_LO  = 0;

  // status register field positions
  localparam int ACR_STAT_HALT = 13;

  // reset values and writable masks
  localparam logic [15:0] ACR_CTL_RST   = 16'h00C3;
  localparam logic [15:0] ACR_CTL_WMASK = 16'hE0D3;
  localparam logic [15:0] ACR_STAT_RST  = 16'h0000;
  localparam logic [15:0] ACR_STAT_WMASK = 16'h2000;

  // interrupt edge select codes
  localparam logic [1:0] ACR_EDGE_OFF  = 2'h0;
  localparam logic [1:0] ACR_EDGE_RISE = 2'h1;
  localparam logic [1:0] ACR_EDGE_FALL = 2'h2;
  localparam logic [1:0] ACR_EDGE_BOTH = 2'h3;

  // inverting input select codes
  localparam logic [1:0] ACR_NEG_PIN_B   = 2'h0;
  localparam logic [1:0] ACR_NEG_PIN_C   = 2'h1;
  localparam logic [1:0] ACR_NEG_PIN_D   = 2'h2;
  localparam logic [1:0] ACR_NEG_ABS_REF = 2'h3;
endpackage

// ---- inc/acr_cmp_if.sv ----
// link between the register bank and one comparator unit
`timescale 1ns/1ps
interface acr_cmp_if;
  logic [15:0] ctl;
  logic        operate;
  logic        raw;
  logic        result;
  logic        evt;

  modport regs (output ctl, output operate, output raw, input result, input evt);
  modport unit (input ctl, input operate, input raw, output result, output evt);
endinterface

// ---- core/acr_cmp_unit.sv ----
// one comparator: result capture, inversion and edge event detection
`timescale 1ns/1ps
module acr_cmp_unit (
  // clock and reset
  input  wire logic  i_clk,
  input  wire logic  i_rstn,
  input  wire logic  i_ce,
  // register bank side
  acr_cmp_if.unit    bus
);
  import acr_pkg::*;

  typedef struct packed {
    logic result;
    logic live;
  } acr_unit_state_t;

  acr_unit_state_t st_r;
  acr_unit_state_t st_nxt;
  logic            value;
  logic            rise;
  logic            fall;
  logic [1:0]      sel;

  // next result and edge event
  always_comb begin
    st_nxt      = st_r;
    value       = bus.raw ^ bus.ctl[ACR_CTL_INV];
    st_nxt.result = bus.operate ? value : 1'b0;
    st_nxt.live = bus.operate;
    rise        = st_r.live & bus.operate & ~st_r.result & value;
    fall        = st_r.live & bus.operate & st_r.result & ~value;
    sel         = bus.ctl[ACR_CTL_EDGE_LO +: 2];
    case (sel)
      ACR_EDGE_OFF:  bus.evt = 1'b0;
      ACR_EDGE_RISE: bus.evt = rise;
      ACR_EDGE_FALL: bus.evt = fall;
      ACR_EDGE_BOTH: bus.evt = rise | fall;
      default:       bus.evt = 1'b0;
    endcase
  end

  // state register, frozen while clock enable is low
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      st_r <= '0;
    end else if (i_ce) begin
      st_r <= st_nxt;
    end
  end

  assign bus.result = st_r.result;
endmodule

// ---- core/acr_regs.sv ----
// register bank of three analog comparators behind a wishbone slave
`timescale 1ns/1ps

// Overview of operation
// - Three comparators each own a control register at A000, A010 and A020, and one shared status sits at A060.
// - Each control and status register has clear, set and toggle aliases at base plus 4, 8 and C that touch only bits written as one.
// - Control registers reset to 00C3 in the low half and zero above, the status register to zero.
// - Control holds enable 15, pin drive 14, invert 13, read-only result 8, edge select 7:6, positive 4, inverting 1:0.
// - Bits 31:16 and every unlisted bit read zero and ignore writes, except status bit 13, halt_in_idle, and bits 2:0, which read the three comparator results.
// - The invert bit flips the result seen both on the pin path and in the readable result bit.
// - Each comparator's inputs are chosen from pins or references by the positive and inverting select fields.
// - The edge select field gives no interrupt, rising, falling or both edges for codes 00, 01, 10 and 11.
// - The invert bit also flips the signal seen by the edge detector.
// - With halt_in_idle set all comparators stop while the device idles, otherwise they keep running.
// - Changing the enable bit alters only the operating state and no other control bit.
module acr_regs #(
  parameter int ADDR_W = acr_pkg::ACR_AW
) (
  // clock, reset and clock enable
  input  wire logic                        I_CLK_SYS,
  input  wire logic                        I_RSTN,
  input  wire logic                        I_CE,
  // wishbone slave
  input  wire logic                        I_WB_CYC,
  input  wire logic                        I_WB_STB,
  input  wire logic                        I_WB_WE,
  input  wire logic [ADDR_W-1:0]           I_WB_ADR,
  input  wire logic [3:0]                  I_WB_SEL,
  input  wire logic [acr_pkg::ACR_DW-1:0]  I_WB_DAT,
  output logic                             O_WB_ACK,
  output logic [acr_pkg::ACR_DW-1:0]       O_WB_DAT,
  // device idle state and raw comparator results
  input  wire logic                        I_IDLE,
  input  wire logic [acr_pkg::ACR_NCMP-1:0] I_CMP_RAW,
  // analog front end control
  output logic [acr_pkg::ACR_NCMP-1:0]     O_CMP_ON,
  output logic [acr_pkg::ACR_NCMP-1:0]     O_POS_PROG_REF,
  output logic [2*acr_pkg::ACR_NCMP-1:0]   O_NEG_SEL,
  // result pins
  output logic [acr_pkg::ACR_NCMP-1:0]     O_CMP_PIN,
  output logic [acr_pkg::ACR_NCMP-1:0]     O_CMP_PIN_OE,
  // interrupt
  output logic                             O_IRQ
);
  import acr_pkg::*;

  // the decoder uses offset bits up to bit 15; control and status decode ignores bits 1:0
  if (ADDR_W < ACR_AW) begin : g_chk
    $error("acr_regs: ADDR_W must be at least 16");
  end

  typedef struct packed {
    logic [ACR_NCMP-1:0][15:0] ctl;
    logic                      halt;
    logic [ACR_NCMP-1:0]       irq_stat;
    logic [ACR_NCMP-1:0]       irq_en;
    logic                      ack;
    logic [ACR_DW-1:0]         dat;
  } acr_regs_state_t;

  acr_regs_state_t     st_r;
  acr_regs_state_t     st_nxt;
  logic [ACR_NCMP-1:0] res_w;
  logic [ACR_NCMP-1:0] evt_w;
  logic [ACR_NCMP-1:0] run_w;
  logic                req;
  logic                wr_commit;
  logic [15:0]         base;
  logic [15:0]         full_adr;
  logic [1:0]          kind;
  logic [15:0]         bmask;
  logic [ACR_NCMP-1:0] ctl_hit;
  logic                stat_hit;
  logic [ACR_DW-1:0]   rd_val;
  logic [15:0]         stat_word;
  logic [ACR_NCMP-1:0] irq_clr;
  logic [15:0]         stat_new;

  // alias write: plain, clear, set or toggle, limited to writable bits
  function automatic logic [15:0] acr_apply(input logic [15:0] old, input logic [15:0] wd,
                                            input logic [15:0] msk, input logic [1:0] k);
    logic [15:0] m;
    m = wd & msk;
    case (k)
      ACR_ALIAS_RW:  acr_apply = (old & ~msk) | m;
      ACR_ALIAS_CLR: acr_apply = old & ~m;
      ACR_ALIAS_SET: acr_apply = old | m;
      ACR_ALIAS_INV: acr_apply = old ^ m;
      default:       acr_apply = old;
    endcase
  endfunction

  // per comparator operating state: enable bit gated by idle halt
  always_comb begin
    for (int i = 0; i < ACR_NCMP; i++) begin
      run_w[i] = st_r.ctl[i][ACR_CTL_ON] & ~(st_r.halt & I_IDLE);
    end
  end

  // comparator units, one per instance
  acr_cmp_if cif[ACR_NCMP] ();
  for (genvar g = 0; g < ACR_NCMP; g++) begin : g_cmp
    assign cif[g].ctl     = st_r.ctl[g];
    assign cif[g].operate = run_w[g];
    assign cif[g].raw     = I_CMP_RAW[g];
    assign res_w[g]       = cif[g].result;
    assign evt_w[g]       = cif[g].evt;
    acr_cmp_unit u_cmp (
      .i_clk  (I_CLK_SYS),
      .i_rstn (I_RSTN),
      .i_ce   (I_CE),
      .bus    (cif[g])
    );
  end

  // address decode
  always_comb begin
    full_adr = I_WB_ADR[15:0];
    base     = {full_adr[15:4], 4'h0};
    kind     = full_adr[ACR_ALIAS_LSB +: 2];
    ctl_hit  = '0;
    ctl_hit[0] = (base == ACR_OFS_CTL1);
    ctl_hit[1] = (base == ACR_OFS_CTL2);
    ctl_hit[2] = (base == ACR_OFS_CTL3);
    stat_hit   = (base == ACR_OFS_STAT);
    if (ADDR_W > ACR_AW) begin
      if (|(I_WB_ADR >> ACR_AW)) begin
        ctl_hit  = '0;
        stat_hit = 1'b0;
      end
    end
    bmask = {{8{I_WB_SEL[1]}}, {8{I_WB_SEL[0]}}};
  end

  // read data: aliases and clear register read zero, upper halves zero
  always_comb begin
    rd_val    = '0;
    stat_word = '0;
    stat_word[ACR_STAT_HALT]   = st_r.halt;
    stat_word[ACR_NCMP-1:0]    = res_w;
    if (kind == ACR_ALIAS_RW) begin
      for (int i = 0; i < ACR_NCMP; i++) begin
        if (ctl_hit[i]) begin
          rd_val[15:0] = st_r.ctl[i] & ACR_CTL_WMASK;
          rd_val[ACR_CTL_RES] = res_w[i];
        end
      end
      if (stat_hit) begin
        rd_val[15:0] = stat_word;
      end
    end
    if (full_adr == ACR_OFS_IRQ_STAT) begin
      rd_val[ACR_NCMP-1:0] = st_r.irq_stat;
    end
    if (full_adr == ACR_OFS_IRQ_EN) begin
      rd_val[ACR_NCMP-1:0] = st_r.irq_en;
    end
  end

  // next state: bus handshake, register writes and sticky events
  always_comb begin
    st_nxt    = st_r;
    // status word as an alias write would leave it, used only on a status hit
    stat_new  = acr_apply(ACR_STAT_RST | (16'(st_r.halt) << ACR_STAT_HALT),
                          I_WB_DAT[15:0], ACR_STAT_WMASK & bmask, kind);
    req       = I_WB_CYC & I_WB_STB;
    wr_commit = req & st_r.ack & I_WB_WE;
    irq_clr   = '0;
    // ack one cycle after the request, dropped in the following cycle
    st_nxt.ack = req & ~st_r.ack;
    if (req & ~st_r.ack & ~I_WB_WE) begin
      st_nxt.dat = rd_val;
    end
    if (wr_commit) begin
      for (int i = 0; i < ACR_NCMP; i++) begin
        if (ctl_hit[i]) begin
          st_nxt.ctl[i] = acr_apply(st_r.ctl[i], I_WB_DAT[15:0],
                                    ACR_CTL_WMASK & bmask, kind);
        end
      end
      if (stat_hit) begin
        st_nxt.halt = stat_new[ACR_STAT_HALT];
      end
      if (full_adr == ACR_OFS_IRQ_EN && I_WB_SEL[0]) begin
        st_nxt.irq_en = I_WB_DAT[ACR_NCMP-1:0];
      end
      if (full_adr == ACR_OFS_IRQ_CLR && I_WB_SEL[0]) begin
        irq_clr = I_WB_DAT[ACR_NCMP-1:0];
      end
    end
    // a new event wins over a clear in the same cycle
    st_nxt.irq_stat = (st_r.irq_stat & ~irq_clr) | evt_w;
  end

  // state register, frozen while clock enable is low
  always_ff @(posedge I_CLK_SYS or negedge I_RSTN) begin
    if (!I_RSTN) begin
      st_r.ctl      <= {ACR_NCMP{ACR_CTL_RST}};
      st_r.halt     <= ACR_STAT_RST[ACR_STAT_HALT];
      st_r.irq_stat <= '0;
      st_r.irq_en   <= '0;
      st_r.ack      <= 1'b0;
      st_r.dat      <= '0;
    end else if (I_CE) begin
      st_r <= st_nxt;
    end
  end

  // output drive
  always_comb begin
    O_WB_ACK = st_r.ack;
    O_WB_DAT = st_r.dat;
    O_IRQ    = |(st_r.irq_stat & st_r.irq_en);
    O_CMP_ON = run_w;
    for (int i = 0; i < ACR_NCMP; i++) begin
      O_POS_PROG_REF[i]    = st_r.ctl[i][ACR_CTL_POS];
      O_NEG_SEL[2*i +: 2]  = st_r.ctl[i][ACR_CTL_NEG_LO +: 2];
      O_CMP_PIN[i]         = res_w[i];
      O_CMP_PIN_OE[i]      = st_r.ctl[i][ACR_CTL_OE] & run_w[i];
    end
  end
endmodule

// ---- tb/acr_regs_chk.sv ----
// port assertions for the comparator register bank
`timescale 1ns/1ps
module acr_regs_chk #(
  parameter int ADDR_W = 16
) (
  // clock, reset and bus
  input wire logic              I_CLK_SYS,
  input wire logic              I_RSTN,
  input wire logic              I_CE,
  input wire logic              I_WB_CYC,
  input wire logic              I_WB_STB,
  input wire logic              I_WB_WE,
  input wire logic [ADDR_W-1:0] I_WB_ADR,
  input wire logic              O_WB_ACK,
  input wire logic [31:0]       O_WB_DAT,
  // comparator side
  input wire logic [2:0]        I_CMP_RAW,
  input wire logic [2:0]        O_CMP_ON,
  input wire logic [2:0]        O_CMP_PIN,
  input wire logic [2:0]        O_CMP_PIN_OE
);
  default clocking cb @(posedge I_CLK_SYS); endclocking
  default disable iff (!I_RSTN);
  // bus answer timing
  a_ack_next_cycle: assert property (I_CE && I_WB_CYC && I_WB_STB && !O_WB_ACK |=> O_WB_ACK)
    else $error("ack missing after request");
  a_ack_one_pulse: assert property (I_CE && O_WB_ACK |=> !O_WB_ACK)
    else $error("ack longer than one cycle");
  a_ack_needs_req: assert property (I_CE && !(I_WB_CYC && I_WB_STB) |=> !O_WB_ACK)
    else $error("ack without request");
  // read data layout
  a_upper_read_zero: assert property (O_WB_ACK && !I_WB_WE |-> O_WB_DAT[31:16] == 16'h0000)
    else $error("upper read bits not zero");
  a_alias_read_zero: assert property (O_WB_ACK && !I_WB_WE && I_WB_ADR < 16'hA080 && I_WB_ADR[3:2] != 2'h0
    |-> O_WB_DAT == 32'h00000000)
    else $error("alias read not zero");
  a_ctl_gap_zero: assert property (O_WB_ACK && !I_WB_WE && I_WB_ADR inside {16'hA000, 16'hA010, 16'hA020}
    |-> (O_WB_DAT & 32'hFFFF1E2C) == 32'h00000000) else $error("unused control bit set");
  // result path
  a_oe_needs_on: assert property ((O_CMP_PIN_OE & ~O_CMP_ON) == 3'h0)
    else $error("pin driven while comparator off");
  a_pin_off_zero: assert property (I_CE |=> (~$past(O_CMP_ON) & O_CMP_PIN) == 3'h0)
    else $error("result not zero while off");
  a_pin_follows_raw: assert property (I_CE && $past(I_CE) && O_CMP_ON[0] && $past(O_CMP_ON[0]) && !I_WB_CYC
    && !$past(I_WB_CYC) && $changed(I_CMP_RAW[0]) |=> $changed(O_CMP_PIN[0])) else $error("result missed change");
endmodule
bind acr_regs acr_regs_chk #(.ADDR_W(ADDR_W)) u_chk (.I_CLK_SYS(I_CLK_SYS), .I_RSTN(I_RSTN), .I_CE(I_CE),
  .I_WB_CYC(I_WB_CYC), .I_WB_STB(I_WB_STB), .I_WB_WE(I_WB_WE), .I_WB_ADR(I_WB_ADR), .O_WB_ACK(O_WB_ACK),
  .O_WB_DAT(O_WB_DAT), .I_CMP_RAW(I_CMP_RAW), .O_CMP_ON(O_CMP_ON), .O_CMP_PIN(O_CMP_PIN),
  .O_CMP_PIN_OE(O_CMP_PIN_OE));

// ---- tb/tb_top.sv ----
// self-checking bench for the comparator register bank
`timescale 1ns/1ps
module tb_top;
  import acr_pkg::*;
  logic        clk = 1'b0, rstn = 1'b0, cyc = 1'b0, stb = 1'b0, we = 1'b0, idle = 1'b0, ack, irq;
  logic        ce = 1'b1;
  logic [15:0] adr = 16'h0000;
  logic [31:0] wdat = 32'h00000000, rdat, q, s = 32'h00004DA5;
  logic [2:0]  raw = 3'h0, on, pos, pin, oe;
  logic [5:0]  neg;
  logic [15:0] m [3];
  int          fail_count = 0, tests_run = 0;
  // 40 MHz system clock
  always #12.5 clk = ~clk;
  acr_regs DUT (.I_CLK_SYS(clk), .I_RSTN(rstn), .I_CE(ce), .I_WB_CYC(cyc), .I_WB_STB(stb), .I_WB_WE(we),
    .I_WB_ADR(adr), .I_WB_SEL(4'hF), .I_WB_DAT(wdat), .O_WB_ACK(ack), .O_WB_DAT(rdat), .I_IDLE(idle),
    .I_CMP_RAW(raw), .O_CMP_ON(on), .O_POS_PROG_REF(pos), .O_NEG_SEL(neg), .O_CMP_PIN(pin),
    .O_CMP_PIN_OE(oe), .O_IRQ(irq));
  // xorshift step of the random state
  function automatic void step();
    s = s ^ (s << 13);
    s = s ^ (s >> 17);
    s = s ^ (s << 5);
  endfunction
  // expected result bit and control read value
  function automatic logic res(input int i);
    return m[i][15] & (raw[i] ^ m[i][13]);
  endfunction
  function automatic logic [31:0] expv(input int i);
    return {16'h0000, m[i] | {7'h00, res(i), 8'h00}};
  endfunction
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      fail_count++;
      $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic summarize();
    $display("comparisons %0d mismatches %0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  // one classic wishbone cycle, bounded wait for ack
  task automatic wb(input logic w, input logic [15:0] a, input logic [31:0] d);
    int n;
    @(posedge clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (ack !== 1'b1 && n < 20);
    q = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
    if (n >= 20) begin
      fail_count++;
      summarize();
    end
  endtask
  task automatic rd(input logic [15:0] a, input logic [31:0] e);
    wb(1'b0, a, 32'h00000000);
    chk(q, e);
  endtask
  // alias write of a control register, model updated alike
  task automatic wr(input int i, input logic [1:0] al, input logic [15:0] v);
    logic [15:0] w;
    w = v & ACR_CTL_WMASK;
    case (al)
      2'h0: m[i] = w;
      2'h1: m[i] = m[i] & ~w;
      2'h2: m[i] = m[i] | w;
      default: m[i] = m[i] ^ w;
    endcase
    wb(1'b1, ACR_OFS_CTL1 + 16'(i * 16 + al * 4), {s[31:16], v});
  endtask
  // main sequence
  initial begin
    int i, j, k;
    logic fr;
    repeat (6) @(posedge clk);
    rstn <= 1'b1;
    for (i = 0; i < 3; i++) begin
      m[i] = ACR_CTL_RST;
      rd(ACR_OFS_CTL1 + 16'(i * 16), 32'h000000C3);
    end
    chk({26'h0000000, neg}, 32'h0000003F);
    rd(ACR_OFS_STAT, 32'h00000000);
    for (k = 0; k < 60; k++) begin
      step();
      @(posedge clk);
      raw <= s[2:0];
      i = int'(s[5:4]) % 3;
      step();
      wr(i, s[9:8], s[15:0]);
      repeat (2) @(negedge clk);
      chk({29'h0, on[i], pos[i], oe[i]}, {29'h0, m[i][15], m[i][4], m[i][15] & m[i][14]});
      chk({30'h0, neg[2*i +: 2]}, {30'h0, m[i][1:0]});
      chk({31'h0, pin[i]}, {31'h0, res(i)});
      rd(ACR_OFS_CTL1 + 16'(i * 16), expv(i));
      rd(ACR_OFS_CTL1 + 16'(i * 16 + 12), 32'h00000000);
      rd(ACR_OFS_STAT, {29'h0, res(2), res(1), res(0)});
    end
    // clock enable low freezes the result flops, raising it lets them catch up
    q = {29'h0, res(2), res(1), res(0)};
    @(posedge clk);
    ce <= 1'b0;
    raw <= ~raw;
    repeat (3) @(negedge clk);
    chk({29'h0, pin}, q);
    @(posedge clk);
    ce <= 1'b1;
    repeat (2) @(negedge clk);
    chk({29'h0, pin}, {29'h0, res(2), res(1), res(0)});
    rd(16'hA040, 32'h00000000);
    wr(0, 2'h2, 16'h8000);
    rd(ACR_OFS_CTL1, expv(0));
    wb(1'b1, ACR_OFS_STAT + 16'h0008, 32'h00002000);
    @(posedge clk);
    idle <= 1'b1;
    repeat (2) @(negedge clk);
    chk({29'h0, on}, 32'h00000000);
    rd(ACR_OFS_STAT, 32'h00002000);
    // halt cleared: comparators keep running although the device stays idle
    @(posedge clk);
    raw <= 3'h0;
    wb(1'b1, ACR_OFS_STAT + 16'h0004, 32'h00002000);
    repeat (2) @(negedge clk);
    chk({29'h0, on}, {29'h0, m[2][15], m[1][15], m[0][15]});
    wb(1'b1, ACR_OFS_IRQ_EN, 32'h00000001);
    for (k = 0; k < 8; k++) begin
      wr(0, 2'h0, {2'h2, k[2], 5'h00, k[1:0], 6'h00});
      wb(1'b1, ACR_OFS_IRQ_CLR, 32'h00000007);
      for (j = 0; j < 2; j++) begin
        @(posedge clk);
        raw[0] <= ~raw[0];
        repeat (3) @(negedge clk);
        fr = (raw[0] ^ k[2]) ? k[0] : k[1];
        chk({31'h0, irq}, {31'h0, fr});
        wb(1'b1, ACR_OFS_IRQ_CLR, 32'h00000007);
      end
    end
    @(posedge clk);
    raw[0] <= 1'b1;
    repeat (3) @(negedge clk);
    chk({31'h0, irq}, 32'h00000001);
    wb(1'b1, ACR_OFS_IRQ_EN, 32'h00000000);
    @(negedge clk);
    chk({31'h0, irq}, 32'h00000000);
    summarize();
  end
endmodule
